// *** verilog/boot_loader_defs.vh ***
// Constants for the tile boot image loader.
`ifndef BOOT_LOADER_DEFS_VH
`define BOOT_LOADER_DEFS_VH

`define BIL_RST_CYC 12'h7d0
`define BIL_SCK_LAST 3'h3
`define BIL_SEC_BIT 5
`define BIL_SEC_ROW 11'h7ff
`define BIL_OTP_BASE 11'h000
`define BIL_SEC_RESET 32'h00000000
`define BIL_SKIP_WORD 32'h0d15ab1e
`define BIL_CRC_POLY 32'hedb88320
`define BIL_CRC_SEED 32'hffffffff
`define BIL_FL_CMD 8'h6b
`define BIL_FL_ADDR 24'h000000
`define BIL_FL_SERIAL 6'd32
`define BIL_FL_DATA 6'd41

`endif

// *** verilog/crc32_byte.v ***
// One byte step of the reflected CRC-32.
`timescale 1ns/1ns
`include "boot_loader_defs.vh"
module crc32_byte (
    input wire [31:0] crcIn,
    input wire [7:0] dataIn,
    output reg [31:0] crcOut
);
    integer i;
    reg [31:0] c;

    always @*
    begin
        c = crcIn ^ {24'h000000, dataIn};
        for (i = 0; i < 8; i = i + 1)
        begin
            if (c[0])
            begin
                c = (c >> 1) ^ `BIL_CRC_POLY;
            end
            else
            begin
                c = c >> 1;
            end
        end
        crcOut = c;
    end
endmodule

// *** verilog/boot_image_loader.v ***
// Reset release and boot image loader for one tile.
`timescale 1ns/1ns
`include "boot_loader_defs.vh"
module boot_image_loader (
    input wire clk_sys,
    input wire reset_n,
    input wire clkEn,
    output reg gpioPullDown,
    output reg otpRd,
    output reg [10:0] otpAddr,
    input wire [31:0] otpData,
    output reg flashCsN,
    output reg flashSck,
    output reg [3:0] flashIoOut,
    output reg [3:0] flashIoOe,
    input wire [3:0] flashIoIn,
    output reg ramWe,
    output reg [14:0] ramAddr,
    output reg [31:0] ramData,
    output reg [31:0] secReg,
    output reg runStart,
    output reg bootFail
);
    localparam [2:0] ST_RST = 3'h0;
    localparam [2:0] ST_SECRD = 3'h1;
    localparam [2:0] ST_SECWAIT = 3'h2;
    localparam [2:0] ST_SECCAP = 3'h3;
    localparam [2:0] ST_LOAD = 3'h4;
    localparam [2:0] ST_RUN = 3'h5;
    localparam [2:0] ST_FAIL = 3'h6;
    localparam [1:0] F_LEN = 2'h0;
    localparam [1:0] F_PROG = 2'h1;
    localparam [1:0] F_CHK = 2'h2;
    localparam [11:0] RST_CYC = `BIL_RST_CYC;
    localparam [2:0] SCK_LAST = `BIL_SCK_LAST;

    reg rstMeta_q, rstSync_q;
    reg [3:0] ioMeta_q, ioSync_q;
    reg [2:0] state_q;
    reg [11:0] rstCnt_q;
    reg secure_q;
    reg [1:0] field_q, byteIdx_q;
    reg [31:0] word_q, lenWords_q, wordCnt_q, crc_q;
    reg [2:0] otpPh_q;
    reg [31:0] otpWord_q;
    reg [2:0] divCnt_q;
    reg [5:0] sckCnt_q;
    reg [31:0] serial_q;
    reg [7:0] flByte_q;
    reg flNib_q, flValid_q;
    reg srcValid;
    reg [7:0] srcByte;
    wire [31:0] crcNext;
    wire [31:0] fullWord;
    wire rstN;
    wire loading;

    assign rstN = rstSync_q;
    assign loading = (state_q == ST_LOAD);
    assign fullWord = {srcByte, word_q[31:8]};

    // ************************************************************
    // Reset release and pin pull-downs.
    // ************************************************************
    // held in reset.
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
            gpioPullDown <= 1'b1;
        end
        else if (clkEn)
        begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
            gpioPullDown <= ~rstSync_q;
        end
    end

    always @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
        begin
            ioMeta_q <= 4'h0;
            ioSync_q <= 4'h0;
        end
        else if (clkEn)
        begin
            ioMeta_q <= flashIoIn;
            ioSync_q <= ioMeta_q;
        end
    end

    // ************************************************************
    // Byte source selection.
    // ************************************************************
    always @*
    begin
        srcValid = 1'b0;
        srcByte = flByte_q;
        if (loading && secure_q)
        begin
            srcValid = (otpPh_q >= 3'h3);
            srcByte = otpWord_q[8 * (otpPh_q - 3'h3) +: 8];
        end
        else if (loading)
        begin
            srcValid = flValid_q;
        end
    end

    crc32_byte crcStep (
        .crcIn(crc_q),
        .dataIn(srcByte),
        .crcOut(crcNext)
    );

    // ************************************************************
    // Boot sequencer and image parser.
    // ************************************************************
    always @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
        begin
            state_q <= ST_RST;
            rstCnt_q <= 12'h000;
            secReg <= `BIL_SEC_RESET;
            secure_q <= 1'b0;
            otpRd <= 1'b0;
            otpAddr <= `BIL_OTP_BASE;
            otpPh_q <= 3'h0;
            otpWord_q <= 32'h00000000;
            field_q <= F_LEN;
            byteIdx_q <= 2'h0;
            word_q <= 32'h00000000;
            lenWords_q <= 32'h00000000;
            wordCnt_q <= 32'h00000000;
            crc_q <= `BIL_CRC_SEED;
            ramWe <= 1'b0;
            ramAddr <= 15'h0000;
            ramData <= 32'h00000000;
            runStart <= 1'b0;
            bootFail <= 1'b0;
        end
        else if (clkEn)
        begin
            ramWe <= 1'b0;
            case (state_q)
                ST_RST:
                begin
                    if (rstCnt_q == RST_CYC - 12'h001)
                    begin
                        state_q <= ST_SECRD;
                    end
                    rstCnt_q <= rstCnt_q + 12'h001;
                end
                ST_SECRD:
                begin
                    otpRd <= 1'b1;
                    otpAddr <= `BIL_SEC_ROW;
                    state_q <= ST_SECWAIT;
                end
                ST_SECWAIT:
                begin
                    otpRd <= 1'b0;
                    state_q <= ST_SECCAP;
                end
                ST_SECCAP:
                begin
                    secReg <= otpData;
                    secure_q <= otpData[`BIL_SEC_BIT];
                    otpAddr <= `BIL_OTP_BASE;
                    state_q <= ST_LOAD;
                end
                ST_LOAD:
                begin
                    if (secure_q)
                    begin
                        otpPh_q <= otpPh_q + 3'h1;
                        otpRd <= (otpPh_q == 3'h0);
                        if (otpPh_q == 3'h2)
                        begin
                            otpWord_q <= otpData;
                        end
                        if (otpPh_q == 3'h6)
                        begin
                            otpPh_q <= 3'h0;
                            otpAddr <= otpAddr + 11'h001;
                        end
                    end
                    if (srcValid)
                    begin
                        byteIdx_q <= byteIdx_q + 2'h1;
                        word_q <= fullWord;
                        if (field_q != F_CHK)
                        begin
                            crc_q <= crcNext;
                        end
                        if (byteIdx_q == 2'h3)
                        begin
                            case (field_q)
                                F_LEN:
                                begin
                                    lenWords_q <= fullWord;
                                    wordCnt_q <= 32'h00000000;
                                    field_q <= (fullWord == 32'h00000000) ?
                                        F_CHK : F_PROG;
                                end
                                F_PROG:
                                begin
                                    ramWe <= 1'b1;
                                    ramAddr <= wordCnt_q[14:0];
                                    ramData <= fullWord;
                                    wordCnt_q <= wordCnt_q + 32'h00000001;
                                    if (wordCnt_q + 32'h00000001 == lenWords_q)
                                    begin
                                        field_q <= F_CHK;
                                    end
                                end
                                default:
                                begin
                                    otpRd <= 1'b0;
                                    if (fullWord == `BIL_SKIP_WORD ||
                                        fullWord == ~crc_q)
                                    begin
                                        state_q <= ST_RUN;
                                    end
                                    else
                                    begin
                                        state_q <= ST_FAIL;
                                    end
                                end
                            endcase
                        end
                    end
                end
                ST_RUN:
                begin
                    runStart <= 1'b1;
                end
                ST_FAIL:
                begin
                    bootFail <= 1'b1;
                end
                default:
                begin
                    state_q <= ST_RST;
                end
            endcase
        end
    end

    // ************************************************************
    // Quad SPI flash reader.
    // ************************************************************
    // quad read from flash.
    always @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
        begin
            flashCsN <= 1'b1;
            flashSck <= 1'b0;
            flashIoOut <= 4'h0;
            flashIoOe <= 4'h0;
            divCnt_q <= 3'h0;
            sckCnt_q <= 6'h00;
            serial_q <= 32'h00000000;
            flByte_q <= 8'h00;
            flNib_q <= 1'b0;
            flValid_q <= 1'b0;
        end
        else if (clkEn)
        begin
            flValid_q <= 1'b0;
            if (!loading || secure_q)
            begin
                flashCsN <= 1'b1;
                flashSck <= 1'b0;
                flashIoOe <= 4'h0;
                divCnt_q <= 3'h0;
                sckCnt_q <= 6'h00;
                flNib_q <= 1'b0;
                serial_q <= {`BIL_FL_CMD, `BIL_FL_ADDR};
            end
            else if (flashCsN)
            begin
                flashCsN <= 1'b0;
                flashIoOe <= 4'h1;
                flashIoOut <= {3'h0, serial_q[31]};
                serial_q <= {serial_q[30:0], 1'b0};
            end
            else if (divCnt_q == SCK_LAST)
            begin
                divCnt_q <= 3'h0;
                flashSck <= ~flashSck;
                if (flashSck)
                begin
                    if (sckCnt_q != `BIL_FL_DATA)
                    begin
                        sckCnt_q <= sckCnt_q + 6'h01;
                    end
                    if (sckCnt_q + 6'h01 < `BIL_FL_SERIAL)
                    begin
                        flashIoOut <= {3'h0, serial_q[31]};
                        serial_q <= {serial_q[30:0], 1'b0};
                    end
                    else
                    begin
                        flashIoOe <= 4'h0;
                    end
                    if (sckCnt_q + 6'h01 >= `BIL_FL_DATA)
                    begin
                        flByte_q <= {flByte_q[3:0], ioSync_q};
                        flNib_q <= ~flNib_q;
                        flValid_q <= flNib_q;
                    end
                end
            end
            else
            begin
                divCnt_q <= divCnt_q + 3'h1;
            end
        end
    end
endmodule

// *** bench/flash_model.sv ***
// Behavioural model of the embedded quad SPI boot flash.
`timescale 1ns/1ns
module flash_model (
    input wire logic sck,
    input wire logic csN,
    input wire logic si,
    output logic [3:0] io
);
    logic [7:0] img [0:63];
    logic [31:0] cmd;
    int n;
    int k;
    initial
    begin
        io = 4'h0;
        n = 0;
        k = 0;
        cmd = 32'h0;
    end
    // A new frame restarts the command and data counts.
    always @(negedge csN)
    begin
        n = 0;
        k = 0;
        cmd = 32'h0;
    end
    // Released lines show the inverse of the last value.
    always @(posedge csN)
        io = ~io;
    always @(posedge sck)
    begin
        if (!csN && n < 32)
            cmd = {cmd[30:0], si};
        n = n + 1;
    end
    always @(negedge sck)
    begin
        if (!csN && n >= 40)
        begin
            io = k[0] ? img[k / 2][3:0] : img[k / 2][7:4];
            k = k + 1;
        end
    end
endmodule

// *** bench/boot_image_loader_chk.sv ***
// Concurrent checks on the boot image loader ports.
`timescale 1ns/1ns
module boot_image_loader_chk (
    input logic clk_sys,
    input logic reset_n,
    input logic gpioPullDown,
    input logic otpRd,
    input logic [10:0] otpAddr,
    input logic flashCsN,
    input logic flashSck,
    input logic ramWe,
    input logic [14:0] ramAddr,
    input logic [31:0] secReg,
    input logic runStart,
    input logic bootFail
);
    logic [15:0] cnt_q;
    logic seen_q;
    logic [14:0] wr_q;
    logic [10:0] row_q;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    // Cycles since release, first read seen, words written and rows read.
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt_q <= 16'h0000;
            seen_q <= 1'b0;
            wr_q <= 15'h0000;
            row_q <= 11'h000;
        end
        else
        begin
            cnt_q <= cnt_q + {15'h0000, cnt_q != 16'hffff};
            seen_q <= seen_q | otpRd;
            wr_q <= wr_q + {14'h0000, ramWe};
            row_q <= row_q + {10'h000, otpRd && otpAddr != 11'h7ff};
        end
    end
    // ***********
    // Assertions.
    // ***********
    AST_PULLDOWN: assert property (
        $rose(reset_n) |-> gpioPullDown && flashCsN && !otpRd)
        else $error("pull-down or outputs wrong at release");
    AST_PULLDOWN_OFF: assert property (
        $rose(reset_n) |-> ##3 !gpioPullDown)
        else $error("pull-downs still on after reset release");
    AST_RST_PHASE: assert property (
        otpRd && !seen_q |-> cnt_q >= 16'h05dc && cnt_q <= 16'h3a98)
        else $error("boot start outside reset phase window");
    AST_SEC_ROW: assert property (
        otpRd && !seen_q |-> otpAddr == 11'h7ff)
        else $error("first read is not the security row");
    AST_SEC_SRC: assert property (
        otpRd && otpAddr != 11'h7ff |-> secReg[5])
        else $error("image read from one-time memory without bit 5");
    AST_OTP_ADDR: assert property (
        otpRd && otpAddr != 11'h7ff |-> otpAddr == row_q)
        else $error("one-time memory image rows out of order");
    AST_OTP_SPACE: assert property (
        otpRd && otpAddr != 11'h7ff |=> !otpRd [*6])
        else $error("image reads closer than seven cycles");
    AST_RAM_ADDR: assert property (
        ramWe |-> ramAddr == wr_q)
        else $error("program word not at next address");
    AST_RAM_PULSE: assert property (
        ramWe |=> !ramWe)
        else $error("write strobe longer than one cycle");
    AST_FAIL_STOP: assert property (
        bootFail |-> !runStart ##1 !runStart)
        else $error("program started after a failed check");
    AST_SCK_HALF: assert property (
        $rose(flashSck) |=> flashSck [*3] ##1 !flashSck)
        else $error("serial clock high phase not four cycles");
endmodule

bind boot_image_loader boot_image_loader_chk chk (
    .clk_sys(clk_sys), .reset_n(reset_n), .gpioPullDown(gpioPullDown),
    .otpRd(otpRd), .otpAddr(otpAddr), .flashCsN(flashCsN),
    .flashSck(flashSck), .ramWe(ramWe), .ramAddr(ramAddr),
    .secReg(secReg), .runStart(runStart), .bootFail(bootFail));

// *** bench/boot_image_loader_tb.sv ***
// Self-checking bench for the boot image loader.
`timescale 1ns/1ns
module boot_image_loader_tb;
    logic clk_sys, reset_n, clkEn, gpioPullDown, otpRd, flashCsN, flashSck;
    logic ramWe, runStart, bootFail, doneSeen;
    logic [10:0] otpAddr;
    logic [3:0] flashIoOut, flashIoOe, flashIoIn, fmIo;
    logic [14:0] ramAddr;
    logic [31:0] otpData, ramData, secReg, seed;
    logic [31:0] otpMem [0:2047];
    logic [47:0] q[$];
    logic [47:0] expv, seen;
    int miscompares, samples_checked, cyc;
    boot_image_loader uut (.clk_sys(clk_sys), .reset_n(reset_n),
        .clkEn(clkEn), .gpioPullDown(gpioPullDown), .otpRd(otpRd),
        .otpAddr(otpAddr), .otpData(otpData), .flashCsN(flashCsN),
        .flashSck(flashSck), .flashIoOut(flashIoOut), .flashIoOe(flashIoOe),
        .flashIoIn(flashIoIn), .ramWe(ramWe), .ramAddr(ramAddr),
        .ramData(ramData), .secReg(secReg), .runStart(runStart),
        .bootFail(bootFail));
    flash_model fm (.sck(flashSck), .csN(flashCsN), .si(flashIoIn[0]),
        .io(fmIo));
    assign flashIoIn = (flashIoOe & flashIoOut) | (~flashIoOe & fmIo);
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // One-time memory answers in the cycle after a read strobe.
    always @(posedge clk_sys)
        otpData <= (otpRd === 1'b1) ? otpMem[otpAddr] : $random(seed);
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            miscompares = miscompares + 1;
            wrap_up;
        end
    end
    task cmp(input string nm, input logic [47:0] e, input logic [47:0] s);
        samples_checked = samples_checked + 1;
        if (e !== s)
        begin
            miscompares = miscompares + 1;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    function automatic logic [31:0] crcB(input logic [31:0] c,
        input logic [7:0] d);
        int k;
        c = c ^ {24'h0, d};
        for (k = 0; k < 8; k++)
            c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
        return c;
    endfunction
    // Each write or final verdict takes the oldest note.
    always @(posedge clk_sys)
    begin
        if (reset_n === 1'b0)
            doneSeen = 1'b0;
        else if (ramWe === 1'b1 || (!doneSeen && (runStart | bootFail)))
        begin
            expv = (q.size() > 0) ? q.pop_front() : 'x;
            seen = {16'hffff, 30'h0, runStart, bootFail};
            if (ramWe === 1'b1)
                seen = {1'b0, ramAddr, ramData};
            doneSeen = (ramWe !== 1'b1);
            cmp("result", expv, seen);
        end
    end
    task boot(input logic sec, input int nw, input logic bad, input logic skp);
        logic [31:0] wd [0:15];
        logic [31:0] c, sr;
        int i, t;
        begin
            @(posedge clk_sys);
            reset_n <= 1'b0;
            clkEn <= $random(seed);
            sr = $random(seed);
            sr[5] = sec;
            otpMem[2047] = sr;
            wd[0] = nw;
            for (i = 1; i <= nw; i++)
            begin
                wd[i] = $random(seed);
                q.push_back({16'(i - 1), wd[i]});
            end
            c = 32'hffffffff;
            for (i = 0; i < nw * 4 + 4; i++)
                c = crcB(c, wd[i / 4][8 * (i % 4) +: 8]);
            wd[nw + 1] = skp ? 32'h0d15ab1e : ~c ^ {31'h0, bad};
            for (i = 0; i < nw * 4 + 8; i++)
                fm.img[i] = wd[i / 4][8 * (i % 4) +: 8];
            for (i = 0; i < nw + 2; i++)
                otpMem[i] = wd[i];
            q.push_back({16'hffff, 30'h0, !bad, bad});
            repeat (8) @(posedge clk_sys);
            clkEn <= 1'b1;
            reset_n <= 1'b1;
            t = 0;
            while (runStart !== 1'b1 && bootFail !== 1'b1 && t < 20000)
            begin
                @(posedge clk_sys);
                t++;
            end
            repeat (2) @(posedge clk_sys);
            cmp("secReg", {16'h0, sr}, {16'h0, secReg});
            if (!sec)
                cmp("flashCmd", 48'h6b000000, {16'h0, fm.cmd});
            cmp("pending", 48'h0, 48'(q.size()));
        end
    endtask
    task wrap_up;
        if (miscompares == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        seed = 32'h30daa5ab;
        reset_n = 1'b0;
        clkEn = 1'b1;
        otpData = 32'h0;
        miscompares = 0;
        samples_checked = 0;
        cyc = 0;
        boot(1'b0, 3, 1'b0, 1'b0);
        boot(1'b0, 1, 1'b1, 1'b0);
        boot(1'b0, 2, 1'b0, 1'b1);
        boot(1'b0, 0, 1'b0, 1'b0);
        boot(1'b1, 2, 1'b0, 1'b0);
        boot(1'b1, 1, 1'b1, 1'b0);
        wrap_up;
    end
endmodule
